// ==== pkg/tllc_pkg.sv ====
// Package: modes, widths, loopback selections and carrier types for the channel mode control
package tllc_pkg;
	localparam int DATA_W = 20;
	localparam int SLIP_W = 5;
	localparam int FIFO_DEPTH = 16;
	localparam logic [4:0] SLIP_MAX_NARROW = 5'h09;
	localparam logic [4:0] SLIP_MAX_WIDE = 5'h13;
	localparam logic [4:0] SLIP_RESET = 5'h00;
	localparam logic [4:0] WIDTH_8 = 5'h08;
	localparam logic [4:0] WIDTH_10 = 5'h0A;
	localparam logic [4:0] WIDTH_20 = 5'h14;
	localparam logic [1:0] MODE_BASIC = 2'h0;
	localparam logic [1:0] MODE_DETLAT = 2'h1;
	localparam logic [1:0] MODE_VIDEO = 2'h2;
	localparam logic [1:0] MODE_PIPE = 2'h3;
	localparam logic [1:0] LB_NONE = 2'h0;
	localparam logic [1:0] LB_REV_PAR = 2'h1;
	localparam logic [1:0] LB_SERIAL = 2'h2;
	localparam logic [1:0] LB_REV_SER = 2'h3;
	typedef struct packed {
		logic [1:0] mode;
		logic quad_10g;
		logic bonded4;
		logic [4:0] width;
		logic byte_ser;
		logic video_3g;
		logic tx_registered;
		logic ref_eq_low;
		logic pfd_req;
		logic low_latency;
	} tllc_cfg_type;
	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] data;
	} tllc_word_type;
endpackage : tllc_pkg

// ==== logic/tllc_ctrl.sv ====
// Channel mode control: latency buffers, bit-slip, PFD feedback, video widths, loopback select
`timescale 1ns/1ps
`default_nettype none

// Transmit phase FIFO with parameterised width and depth
module tllc_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic push;
	logic pop;
	assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data = mem[rd_ptr[AW-1:0]];
	assign push = ce & in_valid & in_ready;
	assign pop = ce & out_valid & out_ready;
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule : tllc_fifo

module tllc_ctrl
	import tllc_pkg::*;
(
	// Clock, reset, enable
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	// Configuration
	input wire tllc_pkg::tllc_cfg_type CFG,
	input wire logic RECONFIG,
	input wire logic [1:0] LOOP_SEL,
	input wire logic RX_DETECT_LOOP,
	input wire logic POWER_P0,
	input wire logic REV_SER_PRE_CDR,
	// Link clock and serial pins
	input wire logic LINK_CLK,
	input wire logic RX_SERIAL,
	input wire logic RX_SERIAL_RETIMED,
	output logic TX_SERIAL,
	output logic RX_BUF_EN,
	output logic TX_PCS_EN,
	// Transmit fabric path
	input wire logic TX_VALID,
	output logic TX_READY,
	input wire logic [tllc_pkg::DATA_W-1:0] TX_DATA,
	input wire logic [tllc_pkg::SLIP_W-1:0] TX_SLIP,
	// Receive word aligner side
	input wire tllc_pkg::tllc_word_type RX_ALIGNED,
	input wire logic RX_SLIP_REQ,
	input wire logic RX_SYNC,
	output tllc_pkg::tllc_word_type RX_WORD,
	output logic [tllc_pkg::SLIP_W-1:0] RX_SLIP_COUNT,
	// Status
	output tllc_pkg::tllc_word_type SER_WORD,
	output logic [1:0] LOOP_ACTIVE,
	output logic PFD_FEEDBACK,
	output logic PFD_CORE_CLK,
	output logic CFG_ERROR
);
	import tllc_pkg::*;

	logic [2:0] lclk_sync;
	logic [1:0] rx_sync_pin;
	logic [1:0] rxr_sync_pin;
	logic link_edge;
	logic cfg_ok;
	logic [1:0] next_loop;
	logic [4:0] slip_limit;
	logic [4:0] tx_slip_eff;
	logic [4:0] rx_slip_acc;
	logic rx_sync_d;
	logic fifo_valid;
	logic [DATA_W-1:0] fifo_data;
	logic tx_pop;
	logic tx_push;
	logic fifo_ready;
	logic ser_load;
	logic [4:0] tx_level;
	logic [4:0] next_level;
	tllc_word_type tx_reg;
	tllc_word_type tx_src;
	logic [2*DATA_W-1:0] shift;
	logic [4:0] bit_idx;

	function automatic logic loop_allowed(input logic [1:0] sel, input tllc_cfg_type c);
		case (sel)
			LB_REV_PAR: loop_allowed = c.mode == MODE_PIPE;
			LB_SERIAL: loop_allowed = c.mode != MODE_PIPE;
			LB_REV_SER: loop_allowed = !c.quad_10g;
			default: loop_allowed = 1'b1;
		endcase
	endfunction : loop_allowed

	// Pin inputs through two flops; link clock through a third for edge detect
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			lclk_sync <= 3'h0;
			rx_sync_pin <= 2'h0;
			rxr_sync_pin <= 2'h0;
		end else if (CLK_EN) begin
			lclk_sync <= {lclk_sync[1:0], LINK_CLK};
			rx_sync_pin <= {rx_sync_pin[0], RX_SERIAL};
			rxr_sync_pin <= {rxr_sync_pin[0], RX_SERIAL_RETIMED};
		end
	end
	assign link_edge = lclk_sync[1] & ~lclk_sync[2];

	// Mode legality
	always_comb begin
		cfg_ok = 1'b1;
		if (CFG.mode == MODE_VIDEO) begin
			cfg_ok = !CFG.bonded4 && ((CFG.width == WIDTH_20 && CFG.byte_ser) ||
				(CFG.width == WIDTH_10 && !CFG.byte_ser && !CFG.video_3g));
		end
	end
	assign slip_limit = (CFG.width == WIDTH_8 || CFG.width == WIDTH_10) ? SLIP_MAX_NARROW : SLIP_MAX_WIDE;
	assign tx_slip_eff = (TX_SLIP > slip_limit) ? slip_limit : TX_SLIP;

	// Loopback selection
	always_comb begin
		next_loop = LOOP_ACTIVE;
		if (LOOP_SEL == LB_NONE || loop_allowed(LOOP_SEL, CFG)) begin
			if (LOOP_SEL == LB_SERIAL || LOOP_ACTIVE == LB_SERIAL) begin
				if (RECONFIG) begin
					next_loop = LOOP_SEL;
				end
			end else if (LOOP_SEL == LB_REV_PAR) begin
				if (RX_DETECT_LOOP && POWER_P0) begin
					next_loop = LB_REV_PAR;
				end
			end else begin
				next_loop = LOOP_SEL;
			end
		end
		if (!loop_allowed(next_loop, CFG)) begin
			next_loop = LB_NONE;
		end
	end
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			LOOP_ACTIVE <= LB_NONE;
			RX_BUF_EN <= 1'b1;
			TX_PCS_EN <= 1'b1;
			PFD_FEEDBACK <= 1'b0;
			PFD_CORE_CLK <= 1'b0;
			CFG_ERROR <= 1'b0;
		end else if (CLK_EN) begin
			LOOP_ACTIVE <= next_loop;
			RX_BUF_EN <= next_loop != LB_SERIAL;
			TX_PCS_EN <= next_loop != LB_REV_SER;
			PFD_FEEDBACK <= CFG.mode == MODE_DETLAT && CFG.ref_eq_low && CFG.pfd_req;
			PFD_CORE_CLK <= CFG.bonded4;
			CFG_ERROR <= !cfg_ok;
		end
	end

	// Receive slip count and registered receive buffer
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rx_slip_acc <= SLIP_RESET;
			rx_sync_d <= 1'b0;
			RX_SLIP_COUNT <= SLIP_RESET;
			RX_WORD <= '0;
		end else if (CLK_EN) begin
			rx_sync_d <= RX_SYNC;
			if (!RX_SYNC) begin
				if (rx_sync_d) begin
					rx_slip_acc <= SLIP_RESET;
				end else if (RX_SLIP_REQ && CFG.low_latency) begin
					rx_slip_acc <= (rx_slip_acc == slip_limit) ? SLIP_RESET : rx_slip_acc + 5'h01;
				end
			end
			if (RX_SYNC && !rx_sync_d) begin
				RX_SLIP_COUNT <= rx_slip_acc;
			end
			RX_WORD <= RX_ALIGNED;
		end
	end

	// Transmit path: FIFO or single register
	tllc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(CORE_CLK),
		.rst_n(RESET_N),
		.ce(CLK_EN),
		.in_valid(tx_push),
		.in_ready(fifo_ready),
		.in_data(TX_DATA),
		.out_valid(fifo_valid),
		.out_ready(tx_pop),
		.out_data(fifo_data)
	);
	// Word taken only with ready; level keeps ready honest
	assign tx_push = TX_VALID & TX_READY & ~CFG.tx_registered;
	assign next_level = tx_level + 5'(tx_push & fifo_ready) - 5'(tx_pop & fifo_valid);
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			TX_READY <= 1'b0;
			tx_reg <= '0;
			tx_level <= 5'h00;
		end else if (CLK_EN) begin
			TX_READY <= CFG.tx_registered ? 1'b1 : next_level != 5'(FIFO_DEPTH);
			tx_level <= next_level;
			tx_reg <= '{valid: TX_VALID, data: TX_DATA};
		end
	end
	assign ser_load = link_edge & ((bit_idx == CFG.width - 5'h01) | (bit_idx >= WIDTH_20));
	assign tx_pop = ser_load & ~CFG.tx_registered;
	always_comb begin
		tx_src = CFG.tx_registered ? tx_reg : '{valid: fifo_valid, data: fifo_data};
		if (LOOP_ACTIVE == LB_REV_PAR) begin
			tx_src = RX_ALIGNED;
		end
	end

	// Serializer with slip delay
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			shift <= '0;
			bit_idx <= 5'h00;
			SER_WORD <= '0;
			TX_SERIAL <= 1'b0;
		end else if (CLK_EN) begin
			if (link_edge) begin
				if (ser_load) begin
					bit_idx <= 5'h00;
					shift <= {tx_src.valid ? tx_src.data : shift[DATA_W-1:0], shift[2*DATA_W-1:DATA_W]};
					SER_WORD <= tx_src;
				end else begin
					bit_idx <= bit_idx + 5'h01;
				end
				if (LOOP_ACTIVE == LB_REV_SER) begin
					TX_SERIAL <= REV_SER_PRE_CDR ? rx_sync_pin[1] : rxr_sync_pin[1];
				end else begin
					TX_SERIAL <= shift[6'(DATA_W) + 6'(bit_idx) - 6'(tx_slip_eff)];
				end
			end
		end
	end

	a_rx_reg_latency: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		CLK_EN |=> RX_WORD == $past(RX_ALIGNED)) else $error("receive buffer latency not one cycle");
	a_slip_report: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		CLK_EN && RX_SYNC && !rx_sync_d |=> RX_SLIP_COUNT == $past(rx_slip_acc)) else $error("slip count not reported");
	a_slip_bound: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		(CFG.width == WIDTH_8 || CFG.width == WIDTH_10) |-> tx_slip_eff <= SLIP_MAX_NARROW)
		else $error("transmit slip above nine");
	a_loop_pipe: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		CLK_EN && CFG.mode != MODE_PIPE |=> LOOP_ACTIVE != LB_REV_PAR) else $error("parallel loopback outside pipe");
	a_serial_buf: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		LOOP_ACTIVE == LB_SERIAL |-> !RX_BUF_EN) else $error("input buffer on in serial loopback");
	a_serial_reconf: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		CLK_EN && !RECONFIG && LOOP_ACTIVE != LB_SERIAL |=> LOOP_ACTIVE != LB_SERIAL) else $error("serial loopback no reconfig");
	a_revser_10g: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		CLK_EN && CFG.quad_10g |=> LOOP_ACTIVE != LB_REV_SER) else $error("reverse serial in 10g mode");
	a_pfd_mode: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		CLK_EN && !(CFG.mode == MODE_DETLAT && CFG.ref_eq_low) |=> !PFD_FEEDBACK)
		else $error("pfd feedback wrongly enabled");
	a_video_width: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		CLK_EN && CFG.mode == MODE_VIDEO && CFG.bonded4 |=> CFG_ERROR) else $error("bonded video not flagged");
endmodule : tllc_ctrl
`default_nettype wire

// ==== bench/tllc_link_model.sv ====
// Far-end serial transceiver: link clock and serial receive lines
`timescale 1ns/1ps
`default_nettype none
module tllc_link_model (
	// Control
	input wire logic run,
	input wire logic level,
	// Line side
	output logic link_clk,
	output logic rx_serial,
	output logic rx_retimed
);
	// Link clock runs inside frames, still otherwise
	initial begin
		link_clk = 1'b0;
		forever begin
			#32;
			link_clk = run ? ~link_clk : 1'b0;
		end
	end
	// Raw and retimed copies kept opposite so the two sources differ
	assign rx_serial = level;
	assign rx_retimed = ~level;
endmodule : tllc_link_model
`default_nettype wire

// ==== bench/testbench.sv ====
// Testbench: loopback select, slip report, video widths, PFD and transmit FIFO
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import tllc_pkg::*;
	logic clk, rst_n, rc, det, p0, pre, tx_valid, slip_req, sync, run, level, t, ce;
	logic lclk, rxs, rxr, txs, rx_buf, tx_pcs, tx_ready, pfd, pfd_core, cerr;
	logic [1:0] sel, act;
	logic [4:0] tx_slip, slip_cnt;
	logic [19:0] tx_data;
	logic [8:0] vid [6] = '{9'h068, 9'h014, 9'h0E8, 9'h055, 9'h095, 9'h169};
	tllc_cfg_type cfg;
	tllc_word_type al, rx_word, ser_word;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;
	tllc_link_model link_u (.run(run), .level(level), .link_clk(lclk), .rx_serial(rxs), .rx_retimed(rxr));
	tllc_ctrl dut_u (.CORE_CLK(clk), .RESET_N(rst_n), .CLK_EN(ce), .CFG(cfg), .RECONFIG(rc),
		.LOOP_SEL(sel), .RX_DETECT_LOOP(det), .POWER_P0(p0), .REV_SER_PRE_CDR(pre), .LINK_CLK(lclk),
		.RX_SERIAL(rxs), .RX_SERIAL_RETIMED(rxr), .TX_SERIAL(txs), .RX_BUF_EN(rx_buf), .TX_PCS_EN(tx_pcs),
		.TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data), .TX_SLIP(tx_slip), .RX_ALIGNED(al),
		.RX_SLIP_REQ(slip_req), .RX_SYNC(sync), .RX_WORD(rx_word), .RX_SLIP_COUNT(slip_cnt),
		.SER_WORD(ser_word), .LOOP_ACTIVE(act), .PFD_FEEDBACK(pfd), .PFD_CORE_CLK(pfd_core), .CFG_ERROR(cerr));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			stop_test();
		end
	end
	task step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step
	task check(input string name, input logic [20:0] seen, input logic [20:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task set_loop(input logic [1:0] s, input logic r);
		sel = s;
		rc = r;
		step(2);
	endtask : set_loop
	task stop_test;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		{rst_n, rc, det, p0, pre, tx_valid, slip_req, sync, run, level} = '0;
		ce = 1'b1;
		{sel, tx_slip, tx_data, cfg, al} = '0;
		step(12);
		rst_n = 1'b1;
		step(1);
		check("reset", {rx_buf, tx_pcs, act, cerr}, 5'h18);
		ce = 1'b0;
		set_loop(LB_REV_SER, 0);
		check("frozen", act, LB_NONE);
		ce = 1'b1;
		set_loop(LB_REV_PAR, 0);
		check("rev_par_basic", act, LB_NONE);
		cfg.mode = MODE_PIPE;
		det = 1'b1;
		step(2);
		check("rev_par_no_p0", act, LB_NONE);
		p0 = 1'b1;
		step(2);
		check("rev_par_on", act, LB_REV_PAR);
		set_loop(LB_SERIAL, 1);
		check("serial_pipe", act == LB_SERIAL, 0);
		set_loop(LB_NONE, 1);
		cfg.mode = MODE_BASIC;
		set_loop(LB_SERIAL, 0);
		check("serial_no_rc", act, LB_NONE);
		tx_data = 20'h0017C;
		set_loop(LB_SERIAL, 1);
		check("serial_on", {act, rx_buf}, {LB_SERIAL, 1'b0});
		set_loop(LB_NONE, 0);
		check("serial_hold", act, LB_SERIAL);
		set_loop(LB_NONE, 1);
		check("serial_off", {act, rx_buf}, {LB_NONE, 1'b1});
		cfg.quad_10g = 1'b1;
		set_loop(LB_REV_SER, 1);
		check("rev_ser_quad", act, LB_NONE);
		cfg.quad_10g = 1'b0;
		level = 1'b1;
		pre = 1'b1;
		run = 1'b1;
		step(2);
		check("rev_ser_on", {act, tx_pcs}, {LB_REV_SER, 1'b0});
		step(24);
		check("pre_cdr", txs, 1);
		pre = 1'b0;
		step(24);
		check("post_cdr", txs, 0);
		run = 1'b0;
		set_loop(LB_NONE, 1);
		cfg.mode = MODE_VIDEO;
		for (int i = 0; i < 6; i++) begin
			{cfg.bonded4, cfg.video_3g, cfg.byte_ser, cfg.width} = vid[i][8:1];
			step(2);
			check("video_cfg", cerr, vid[i][0]);
		end
		cfg = '0;
		cfg.mode = MODE_DETLAT;
		cfg.width = WIDTH_10;
		cfg.ref_eq_low = 1'b1;
		cfg.pfd_req = 1'b1;
		step(2);
		check("pfd_x1", {pfd, pfd_core}, 2'b10);
		cfg.bonded4 = 1'b1;
		step(2);
		check("pfd_x4", {pfd, pfd_core}, 2'b11);
		cfg.ref_eq_low = 1'b0;
		step(2);
		check("pfd_off", pfd, 0);
		slip_req = 1'b1;
		step(1);
		{slip_req, sync} = 2'b01;
		step(2);
		check("slip_ignored", slip_cnt, SLIP_RESET);
		{slip_req, sync, cfg.low_latency} = 3'b101;
		step(2);
		{slip_req, sync} = 2'b01;
		step(2);
		check("slip_one", slip_cnt, 5'h01);
		tx_slip = slip_cnt;
		al = '{valid: 1'b1, data: 20'hA5C3F};
		step(1);
		check("rx_word_a", rx_word, 21'h1A5C3F);
		al.data = 20'h05A0C;
		step(1);
		check("rx_word_b", rx_word, 21'h105A0C);
		n = 0;
		tx_data = 20'h00100;
		tx_valid = 1'b1;
		repeat (40) begin
			t = tx_ready;
			step(1);
			if (t) begin
				n++;
				tx_data = tx_data + 20'h00001;
			end
		end
		tx_valid = 1'b0;
		check("fifo_full", {tx_ready, n == FIFO_DEPTH}, 2'b01);
		run = 1'b1;
		n = 0;
		while (tx_ready !== 1'b1 && n < 2000) begin
			step(1);
			n++;
		end
		check("fifo_drain", tx_ready, 1);
		check("fifo_first", ser_word, 21'h100100);
		cfg.tx_registered = 1'b1;
		tx_data = 20'h0ABCD;
		tx_valid = 1'b1;
		step(400);
		check("tx_reg", ser_word, 21'h10ABCD);
		check("tx_reg_ready", tx_ready, 1);
		tx_valid = 1'b0;
		run = 1'b0;
		stop_test();
	end
endmodule : testbench
`default_nettype wire
